// *** rtl/bio_map.svh ***
`ifndef BIO_MAP_SVH
`define BIO_MAP_SVH
// Notes on behaviour
// - The transducer type selector holds bridge option 0, mV/V 1, ratio 2, 1-5V 3, 4-20mA 4, reset 0.
// - Permit_output and the three pressure-switch polarities use 1 for N.C., 0 for N.O.; defaults 1,0,0,0.
// - The passcode holds 0000 to 9999 and resets to zero.
// - With protection on, menu access is granted only after the stored passcode is entered.
// - The passcode enable uses 1 for enabled, 0 for disabled, and resets to 0.
// - The display stays on for the programmed seconds after the last interaction, then goes off.
// - The display timeout is in seconds, accepts 30 to 1800, and resets to 1800.

// ****************************************
// register numbers
// ****************************************
`define BIO_OFF_XDUCER 16'h00C4
`define BIO_OFF_PERMIT 16'h00C5
`define BIO_OFF_SW_ONE 16'h00C6
`define BIO_OFF_SW_TWO 16'h00C7
`define BIO_OFF_SW_THREE 16'h00C8
`define BIO_OFF_CODE 16'h00CD
`define BIO_OFF_CODE_EN 16'h00CE
`define BIO_OFF_DISP 16'h00D2

// ****************************************
// reset values and limits
// ****************************************
`define BIO_RST_XDUCER 16'h0000
`define BIO_RST_PERMIT 16'h0001
`define BIO_RST_SW 16'h0000
`define BIO_RST_CODE 16'h0000
`define BIO_RST_CODE_EN 16'h0000
`define BIO_RST_DISP 16'h0708
`define BIO_XDUCER_MAX 16'h0004
`define BIO_FLAG_MAX 16'h0001
`define BIO_CODE_MAX 16'h270F
`define BIO_DISP_MIN 16'h001E
`define BIO_DISP_MAX 16'h0708
`define BIO_READ_ZERO 16'h0000

// ****************************************
// timing
// ****************************************
`define BIO_SECOND_NS 1000000000
`define BIO_CLK_NS 100
`endif

// *** rtl/bio_pkg.sv ***
package bio_pkg;
	typedef enum logic [1:0] {
		BIO_DISP_OFF = 2'b00,
		BIO_DISP_ON = 2'b01
	} bio_disp_e;

	typedef struct packed {
		logic valid;
		logic we;
		logic [15:0] num;
		logic [15:0] wdata;
	} bio_req_s;

	typedef struct packed {
		logic [15:0] xducer;
		logic [15:0] permit;
		logic [15:0] sw_one;
		logic [15:0] sw_two;
		logic [15:0] sw_three;
		logic [15:0] code;
		logic [15:0] code_en;
		logic [15:0] disp;
	} bio_regs_s;

	typedef struct packed {
		logic [2:0] transducer_type_select;
		logic permit_output_nc;
		logic pressure_switch_one_nc;
		logic pressure_switch_two_nc;
		logic pressure_switch_three_nc;
	} bio_cfg_s;
endpackage : bio_pkg

// *** rtl/bio_bank.sv ***
`timescale 1ns/1ps
`include "bio_map.svh"

module bio_bank
	import bio_pkg::*;
#(
	parameter int SEC_CYCLES = `BIO_SECOND_NS / `BIO_CLK_NS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// holding register port
	input wire bio_req_s reg_req,
	output logic reg_ack,
	output logic [15:0] reg_rdata,
	// front panel
	input wire logic menu_key,
	input wire logic code_try,
	input wire logic [15:0] code_digits,
	// settings and status
	output bio_cfg_s cfg,
	output logic display_on,
	output logic menu_access
);

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic [15:0] read_reg(input logic [15:0] num, input bio_regs_s r);
		case (num)
			`BIO_OFF_XDUCER: read_reg = r.xducer;
			`BIO_OFF_PERMIT: read_reg = r.permit;
			`BIO_OFF_SW_ONE: read_reg = r.sw_one;
			`BIO_OFF_SW_TWO: read_reg = r.sw_two;
			`BIO_OFF_SW_THREE: read_reg = r.sw_three;
			`BIO_OFF_CODE: read_reg = r.code;
			`BIO_OFF_CODE_EN: read_reg = r.code_en;
			`BIO_OFF_DISP: read_reg = r.disp;
			default: read_reg = `BIO_READ_ZERO;
		endcase
	endfunction : read_reg

	function automatic logic is_mapped(input logic [15:0] num);
		case (num)
			`BIO_OFF_XDUCER, `BIO_OFF_PERMIT, `BIO_OFF_SW_ONE, `BIO_OFF_SW_TWO,
			`BIO_OFF_SW_THREE, `BIO_OFF_CODE, `BIO_OFF_CODE_EN, `BIO_OFF_DISP:
				is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	localparam bio_regs_s RST_REGS = '{
		xducer: `BIO_RST_XDUCER,
		permit: `BIO_RST_PERMIT,
		sw_one: `BIO_RST_SW,
		sw_two: `BIO_RST_SW,
		sw_three: `BIO_RST_SW,
		code: `BIO_RST_CODE,
		code_en: `BIO_RST_CODE_EN,
		disp: `BIO_RST_DISP
	};

	// ****************************************
	// register file
	// ****************************************
	bio_regs_s regs;
	bio_regs_s next_regs;
	logic next_ack;
	logic [15:0] next_rdata;
	bio_cfg_s next_cfg;
	logic [15:0] wd;
	logic wr;

	// out-of-range writes are dropped whole so a setting never holds an illegal code
	always_comb
	begin
		next_regs = regs;
		wd = reg_req.wdata;
		wr = reg_req.valid && reg_req.we;
		next_ack = reg_req.valid;
		next_rdata = read_reg(reg_req.num, regs);
		if (wr)
		begin
			case (reg_req.num)
				`BIO_OFF_XDUCER: if (wd <= `BIO_XDUCER_MAX) next_regs.xducer = wd;
				`BIO_OFF_PERMIT: if (wd <= `BIO_FLAG_MAX) next_regs.permit = wd;
				`BIO_OFF_SW_ONE: if (wd <= `BIO_FLAG_MAX) next_regs.sw_one = wd;
				`BIO_OFF_SW_TWO: if (wd <= `BIO_FLAG_MAX) next_regs.sw_two = wd;
				`BIO_OFF_SW_THREE: if (wd <= `BIO_FLAG_MAX) next_regs.sw_three = wd;
				`BIO_OFF_CODE: if (wd <= `BIO_CODE_MAX) next_regs.code = wd;
				`BIO_OFF_CODE_EN: if (wd <= `BIO_FLAG_MAX) next_regs.code_en = wd;
				`BIO_OFF_DISP:
					if (wd >= `BIO_DISP_MIN && wd <= `BIO_DISP_MAX)
						next_regs.disp = wd;
				default: next_regs = regs;
			endcase
		end
		next_cfg.transducer_type_select = next_regs.xducer[2:0];
		next_cfg.permit_output_nc = next_regs.permit[0];
		next_cfg.pressure_switch_one_nc = next_regs.sw_one[0];
		next_cfg.pressure_switch_two_nc = next_regs.sw_two[0];
		next_cfg.pressure_switch_three_nc = next_regs.sw_three[0];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			regs <= RST_REGS;
			reg_ack <= 1'b0;
			reg_rdata <= `BIO_READ_ZERO;
			cfg <= '{
				transducer_type_select: RST_REGS.xducer[2:0],
				permit_output_nc: RST_REGS.permit[0],
				pressure_switch_one_nc: RST_REGS.sw_one[0],
				pressure_switch_two_nc: RST_REGS.sw_two[0],
				pressure_switch_three_nc: RST_REGS.sw_three[0]
			};
		end
		else
		begin
			regs <= next_regs;
			reg_ack <= next_ack;
			reg_rdata <= next_rdata;
			cfg <= next_cfg;
		end
	end

	// ****************************************
	// panel input sync
	// ****************************************
	logic key_meta;
	logic key_sync;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			key_meta <= 1'b0;
			key_sync <= 1'b0;
		end
		else
		begin
			key_meta <= menu_key;
			key_sync <= key_meta;
		end
	end

	// ****************************************
	// display timer and access gate
	// ****************************************
	bio_disp_e disp_state;
	bio_disp_e next_disp_state;
	logic [31:0] tick_cnt;
	logic [31:0] next_tick_cnt;
	logic [15:0] secs_left;
	logic [15:0] next_secs_left;
	logic unlocked;
	logic next_unlocked;
	logic next_access;
	logic touch;
	logic tick;
	logic good_try;

	always_comb
	begin
		touch = key_sync || code_try;
		tick = (tick_cnt == 32'(SEC_CYCLES - 1));
		good_try = code_try && (code_digits == regs.code);
		next_disp_state = disp_state;
		next_tick_cnt = tick ? 32'h00000000 : tick_cnt + 32'h00000001;
		next_secs_left = secs_left;
		next_unlocked = unlocked;
		case (disp_state)
			BIO_DISP_ON:
				if (tick)
				begin
					next_secs_left = secs_left - 16'h0001;
					if (secs_left <= 16'h0001)
					begin
						next_disp_state = BIO_DISP_OFF;
						next_unlocked = 1'b0;
					end
				end
			BIO_DISP_OFF: next_tick_cnt = 32'h00000000;
			default: next_disp_state = BIO_DISP_OFF;
		endcase
		// interaction restarts the interval; set of unlock wins over timeout clear
		if (touch)
		begin
			next_disp_state = BIO_DISP_ON;
			next_secs_left = regs.disp;
			next_tick_cnt = 32'h00000000;
		end
		if (good_try)
			next_unlocked = 1'b1;
		next_access = next_unlocked || (next_regs.code_en == `BIO_RST_CODE_EN);
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			disp_state <= BIO_DISP_ON;
			tick_cnt <= 32'h00000000;
			secs_left <= `BIO_RST_DISP;
			unlocked <= 1'b0;
			display_on <= 1'b1;
			menu_access <= 1'b1;
		end
		else
		begin
			disp_state <= next_disp_state;
			tick_cnt <= next_tick_cnt;
			secs_left <= next_secs_left;
			unlocked <= next_unlocked;
			display_on <= (next_disp_state == BIO_DISP_ON);
			menu_access <= next_access;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	xducer_range_a: assert property (@(posedge clk) disable iff (reset)
		reg_req.valid && reg_req.we && reg_req.num == `BIO_OFF_XDUCER && reg_req.wdata > `BIO_XDUCER_MAX
		|=> $stable(regs.xducer) && 16'(cfg.transducer_type_select) <= `BIO_XDUCER_MAX)
		else $error("transducer type took an illegal code");

	polarity_flag_a: assert property (@(posedge clk) disable iff (reset)
		reg_req.valid && reg_req.we && reg_req.num == `BIO_OFF_PERMIT && reg_req.wdata <= `BIO_FLAG_MAX
		|=> cfg.permit_output_nc == $past(reg_req.wdata[0]))
		else $error("permit_output polarity not updated");

	code_range_a: assert property (@(posedge clk) disable iff (reset)
		regs.code <= `BIO_CODE_MAX)
		else $error("passcode out of range");

	access_gate_a: assert property (@(posedge clk) disable iff (reset)
		regs.code_en[0] && !unlocked && !code_try ##1 !code_try && $stable(regs.code_en) |-> !menu_access)
		else $error("menu access without passcode");

	code_enable_a: assert property (@(posedge clk) disable iff (reset)
		regs.code_en <= `BIO_FLAG_MAX && (regs.code_en != `BIO_RST_CODE_EN || menu_access))
		else $error("passcode enable flag wrong");

	display_wake_a: assert property (@(posedge clk) disable iff (reset)
		key_sync |=> display_on && secs_left == $past(regs.disp))
		else $error("display not restarted on interaction");

	display_range_a: assert property (@(posedge clk) disable iff (reset)
		regs.disp >= `BIO_DISP_MIN && regs.disp <= `BIO_DISP_MAX)
		else $error("display timeout out of range");

	unmapped_read_a: assert property (@(posedge clk) disable iff (reset)
		reg_req.valid && !is_mapped(reg_req.num)
		|=> reg_ack && reg_rdata == `BIO_READ_ZERO && $stable(regs))
		else $error("unused register not inert");

endmodule : bio_bank

// *** tb/bio_master.sv ***
`timescale 1ns/1ps
module bio_master
	import bio_pkg::*;
(
	// clock
	input wire logic clk,
	// holding register port
	output bio_req_s reg_req,
	input wire logic reg_ack,
	input wire logic [15:0] reg_rdata
);
	initial reg_req = '0;

	// strobe is one cycle wide; a held strobe would be taken twice
	task automatic access(input logic we, input logic [15:0] num, input logic [15:0] wd,
		output logic [15:0] rd);
		int n;
		@(posedge clk);
		#1;
		reg_req = '{valid: 1'b1, we: we, num: num, wdata: wd};
		@(posedge clk);
		#1;
		// released lines show the inverse, not the stale word
		reg_req = '{valid: 1'b0, we: ~we, num: ~num, wdata: ~wd};
		for (n = 0; n < 4 && reg_ack !== 1'b1; n++)
			@(posedge clk);
		rd = (reg_ack === 1'b1) ? reg_rdata : 16'hXXXX;
	endtask : access
endmodule : bio_master

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import bio_pkg::*;
;
	typedef struct {logic [15:0] num; logic [15:0] wd; logic [15:0] exp;} bio_row_s;
	logic clk = 0;
	logic reset = 1;
	bio_req_s reg_req;
	logic reg_ack;
	logic [15:0] reg_rdata;
	logic menu_key = 0;
	logic code_try = 0;
	logic [15:0] code_digits = '0;
	bio_cfg_s cfg;
	logic display_on;
	logic menu_access;
	logic [15:0] rd;
	int miscompares = 0;
	int checks = 0;
	bio_row_s init [8] = '{'{16'h00C4, 16'h0000, 16'h0000}, '{16'h00C5, 16'h0000, 16'h0001},
		'{16'h00C6, 16'h0000, 16'h0000}, '{16'h00C7, 16'h0000, 16'h0000},
		'{16'h00C8, 16'h0000, 16'h0000}, '{16'h00CD, 16'h0000, 16'h0000},
		'{16'h00CE, 16'h0000, 16'h0000}, '{16'h00D2, 16'h0000, 16'h0708}};
	// out-of-range writes must leave the register's earlier value in place
	bio_row_s rows [19] = '{'{16'h00C4, 16'h0001, 16'h0001}, '{16'h00C4, 16'h0002, 16'h0002},
		'{16'h00C4, 16'h0003, 16'h0003}, '{16'h00C4, 16'h0004, 16'h0004},
		'{16'h00C4, 16'h0005, 16'h0004}, '{16'h00C5, 16'h0000, 16'h0000},
		'{16'h00C5, 16'h0002, 16'h0000}, '{16'h00C6, 16'h0001, 16'h0001},
		'{16'h00C7, 16'h0001, 16'h0001}, '{16'h00C8, 16'h0001, 16'h0001},
		'{16'h00C8, 16'h0002, 16'h0001}, '{16'h00CD, 16'h270F, 16'h270F},
		'{16'h00CD, 16'h2710, 16'h270F}, '{16'h00D2, 16'h0709, 16'h0708},
		'{16'h00D2, 16'h001D, 16'h0708}, '{16'h00D2, 16'h001E, 16'h001E},
		'{16'h00C9, 16'h0005, 16'h0000}, '{16'h00CF, 16'h0001, 16'h0000},
		'{16'h00D1, 16'hFFFF, 16'h0000}};

	always #50 clk = ~clk;

	bio_bank #(.SEC_CYCLES(4)) dut (.clk(clk), .reset(reset), .reg_req(reg_req),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata), .menu_key(menu_key), .code_try(code_try),
		.code_digits(code_digits), .cfg(cfg), .display_on(display_on),
		.menu_access(menu_access));
	bio_master master (.clk(clk), .reg_req(reg_req), .reg_ack(reg_ack),
		.reg_rdata(reg_rdata));

	// ****************************************
	// helpers
	// ****************************************
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic try_code(input logic [15:0] d);
		code_digits = d;
		code_try = 1;
		tick(1);
		code_try = 0;
		tick(2);
	endtask : try_code

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		tick(20);
		reset = 0;
		cmp("cfg", 16'h0008, {9'h000, cfg});
		cmp("display_on", 16'h0001, {15'h0000, display_on});
		cmp("menu_access", 16'h0001, {15'h0000, menu_access});
		foreach (init[i])
		begin
			master.access(1'b0, init[i].num, 16'h0000, rd);
			cmp("reset value", init[i].exp, rd);
		end
		foreach (rows[i])
		begin
			master.access(1'b1, rows[i].num, rows[i].wd, rd);
			master.access(1'b0, rows[i].num, 16'h0000, rd);
			cmp("readback", rows[i].exp, rd);
		end
		cmp("cfg", 16'h0047, {9'h000, cfg});
		master.access(1'b1, 16'h00CD, 16'h04D2, rd);
		master.access(1'b1, 16'h00CE, 16'h0001, rd);
		tick(1);
		cmp("menu_access", 16'h0000, {15'h0000, menu_access});
		try_code(16'h04D3);
		cmp("menu_access", 16'h0000, {15'h0000, menu_access});
		try_code(16'h04D2);
		cmp("menu_access", 16'h0001, {15'h0000, menu_access});
		// 30 s of 4 cycles; margin covers the prescaler phase
		tick(110);
		cmp("display_on", 16'h0001, {15'h0000, display_on});
		tick(16);
		cmp("display_on", 16'h0000, {15'h0000, display_on});
		cmp("menu_access", 16'h0000, {15'h0000, menu_access});
		menu_key = 1;
		tick(1);
		menu_key = 0;
		tick(4);
		cmp("display_on", 16'h0001, {15'h0000, display_on});
		cmp("menu_access", 16'h0000, {15'h0000, menu_access});
		master.access(1'b1, 16'h00CE, 16'h0002, rd);
		tick(1);
		cmp("menu_access", 16'h0000, {15'h0000, menu_access});
		master.access(1'b1, 16'h00CE, 16'h0000, rd);
		tick(1);
		cmp("menu_access", 16'h0001, {15'h0000, menu_access});
		summarize();
	end

	initial
	begin
		#2000000;
		miscompares++;
		summarize();
	end
endmodule : tb_top
